// [pkg/lsc_params.svh]
// Purpose: constants of the local switch configuration decoder
// Assumes: included by its bare name
// Notes: positions are one-based bank bit indices (position 1 is bit 0)
`ifndef LSC_PARAMS_SVH
`define LSC_PARAMS_SVH

// bank and remote path widths
`define LSC_BANK_W 8
`define LSC_DATA_W 4
`define LSC_SEL_W 3

// first bank positions
`define LSC_A_MODE_BIT 0
`define LSC_A_TXEN_BIT 3

// second bank fields: format is positions 2..5, source positions 6..7
`define LSC_B_FMT_MSB 1
`define LSC_B_FMT_LSB 4
`define LSC_B_SRC_MSB 5
`define LSC_B_SRC_LSB 6

// remote parameter selectors
`define LSC_PID_FMT 3'h0
`define LSC_PID_SRC 3'h1
`define LSC_PID_TXEN 3'h2
`define LSC_PID_ASPECT 3'h3
`define LSC_PID_BARS 3'h4
`define LSC_PID_RELEASE 3'h5

// highest legal format and source codes
`define LSC_FMT_MAX 4'h6
`define LSC_SRC_MAX 2'h2

// defaults of remote-only parameters
`define LSC_ASPECT_RST 2'h0
`define LSC_BARS_RST 1'b0

`endif

// [pkg/lsc_pkg.sv]
// Purpose: types shared by the switch decoder files
// Assumes: lsc_params.svh constants
// Notes: enum order equals the binary switch code
`include "lsc_params.svh"
package lsc_pkg;
    typedef enum logic [3:0] {
        LSC_FMT_AUTO,
        LSC_FMT_1080I50,
        LSC_FMT_1080I5994,
        LSC_FMT_720P50,
        LSC_FMT_720P5994,
        LSC_FMT_480I5994,
        LSC_FMT_576I50
    } lsc_fmt_t;

    typedef enum logic [1:0] {
        LSC_SRC_COAX,
        LSC_SRC_FIBER1,
        LSC_SRC_FIBER2
    } lsc_src_t;

    // codes beyond the table fall back to automatic detection
    function automatic lsc_fmt_t lsc_fmt_decode(input logic [3:0] code);
        lsc_fmt_t f;
        f = LSC_FMT_AUTO;
        if (code <= `LSC_FMT_MAX) begin
            f = lsc_fmt_t'(code);
        end
        return f;
    endfunction

    // code three is unused and is treated as the always-present coax input
    function automatic lsc_src_t lsc_src_decode(input logic [1:0] code);
        lsc_src_t s;
        s = LSC_SRC_COAX;
        if (code <= `LSC_SRC_MAX) begin
            s = lsc_src_t'(code);
        end
        return s;
    endfunction
endpackage

// [rtl/lsc_sw_decode.sv]
// Purpose: register and decode both switch banks
// Assumes: switch inputs synchronous to mclk
// Notes: one cycle from switch to decoded value
`timescale 1ns/1ns
`default_nettype none
`include "lsc_params.svh"
module lsc_sw_decode (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // switch banks
    input wire logic [`LSC_BANK_W-1:0] switch_bank_a,
    input wire logic [`LSC_BANK_W-1:0] switch_bank_b,
    // decoded settings
    output logic remote_mode,
    output logic local_txen,
    output lsc_pkg::lsc_fmt_t local_fmt,
    output lsc_pkg::lsc_src_t local_src
);
    import lsc_pkg::*;

    logic next_remote_mode;
    logic next_local_txen;
    lsc_fmt_t next_local_fmt;
    lsc_src_t next_local_src;

    always_comb begin
        next_remote_mode = switch_bank_a[`LSC_A_MODE_BIT];
        next_local_txen = switch_bank_a[`LSC_A_TXEN_BIT];
        // position 2 is the most significant bit
        next_local_fmt = lsc_fmt_decode({switch_bank_b[`LSC_B_FMT_MSB], switch_bank_b[2],
                                         switch_bank_b[3], switch_bank_b[`LSC_B_FMT_LSB]});
        next_local_src = lsc_src_decode({switch_bank_b[`LSC_B_SRC_MSB],
                                         switch_bank_b[`LSC_B_SRC_LSB]});
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            remote_mode <= 1'b0;
            local_txen <= 1'b0;
            local_fmt <= LSC_FMT_AUTO;
            local_src <= LSC_SRC_COAX;
        end else begin
            remote_mode <= next_remote_mode;
            local_txen <= next_local_txen;
            local_fmt <= next_local_fmt;
            local_src <= next_local_src;
        end
    end

    AST_FMT_1080I5994: assert property (@(posedge mclk) disable iff (!arst_n)
        switch_bank_b[4:1] == 4'h4 |=> local_fmt == LSC_FMT_1080I5994)
        else $error("format code two not decoded");
    AST_FMT_576I: assert property (@(posedge mclk) disable iff (!arst_n)
        switch_bank_b[4:1] == 4'h6 |=> local_fmt == LSC_FMT_576I50)
        else $error("format code six not decoded");
    AST_SRC_FIBER2: assert property (@(posedge mclk) disable iff (!arst_n)
        switch_bank_b[6:5] == 2'h1 |=> local_src == LSC_SRC_FIBER2)
        else $error("source code two not decoded");
endmodule // lsc_sw_decode
`default_nettype wire

// [rtl/lsc_config.sv]
// Purpose: merge switch settings and remote writes into the operating configuration
// Assumes: remote writes are one-cycle strobes synchronous to mclk
// Notes: overrides stay latched in local mode but have no effect until remote mode returns
//
// Functional notes
// - The mode switch on the first bank locks out remote writes when off and accepts them when on.
// - In remote mode a remotely written parameter takes priority over the switch-derived value.
// - Fiber transmit outputs are enabled only with the enable setting on and a transmitter fitted.
// - Some parameters exist only remotely and keep their default or their last remote value.
`timescale 1ns/1ns
`default_nettype none
`include "lsc_params.svh"
module lsc_config (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // onboard switch banks
    input wire logic [`LSC_BANK_W-1:0] switch_bank_a,
    input wire logic [`LSC_BANK_W-1:0] switch_bank_b,
    // fitted fiber transmitters, one bit per output
    input wire logic [1:0] tx_fitted,
    // remote configuration path
    input wire logic remote_wr,
    input wire logic [`LSC_SEL_W-1:0] remote_sel,
    input wire logic [`LSC_DATA_W-1:0] remote_data,
    // write answer
    output logic remote_ack,
    output logic remote_rej,
    // operating configuration
    output lsc_pkg::lsc_fmt_t cfg_fmt,
    output lsc_pkg::lsc_src_t cfg_src,
    output logic [1:0] fiber_tx_en,
    output logic [1:0] cfg_aspect,
    output logic cfg_bars,
    // status
    output logic remote_active,
    output logic [2:0] override_flags
);
    import lsc_pkg::*;

    logic remote_mode;
    logic local_txen;
    lsc_fmt_t local_fmt;
    lsc_src_t local_src;

    lsc_sw_decode u_decode (
        .mclk(mclk),
        .arst_n(arst_n),
        .switch_bank_a(switch_bank_a),
        .switch_bank_b(switch_bank_b),
        .remote_mode(remote_mode),
        .local_txen(local_txen),
        .local_fmt(local_fmt),
        .local_src(local_src)
    );

    // remote store and override state
    lsc_fmt_t rem_fmt;
    lsc_src_t rem_src;
    logic rem_txen;
    logic [2:0] ovr;
    logic [1:0] aspect;
    logic bars;
    lsc_fmt_t next_rem_fmt;
    lsc_src_t next_rem_src;
    logic next_rem_txen;
    logic [2:0] next_ovr;
    logic [1:0] next_aspect;
    logic next_bars;
    logic accept;
    logic reject;

    always_comb begin
        next_rem_fmt = rem_fmt;
        next_rem_src = rem_src;
        next_rem_txen = rem_txen;
        next_ovr = ovr;
        next_aspect = aspect;
        next_bars = bars;
        accept = 1'b0;
        reject = 1'b0;
        // writes in local mode are dropped without an answer, as the lock-out intends
        if (remote_wr && remote_mode) begin
            accept = 1'b1;
            unique case (remote_sel)
                `LSC_PID_FMT: begin
                    if (remote_data <= `LSC_FMT_MAX) begin
                        next_rem_fmt = lsc_fmt_decode(remote_data);
                        next_ovr[0] = 1'b1;
                    end else begin
                        accept = 1'b0;
                        reject = 1'b1;
                    end
                end
                `LSC_PID_SRC: begin
                    if (remote_data <= {2'h0, `LSC_SRC_MAX}) begin
                        next_rem_src = lsc_src_decode(remote_data[1:0]);
                        next_ovr[1] = 1'b1;
                    end else begin
                        accept = 1'b0;
                        reject = 1'b1;
                    end
                end
                `LSC_PID_TXEN: begin
                    next_rem_txen = remote_data[0];
                    next_ovr[2] = 1'b1;
                end
                `LSC_PID_ASPECT: begin
                    next_aspect = remote_data[1:0];
                end
                `LSC_PID_BARS: begin
                    next_bars = remote_data[0];
                end
                `LSC_PID_RELEASE: begin
                    // hand switch-covered parameters back to the switches
                    next_ovr = 3'h0;
                end
                default: begin
                    accept = 1'b0;
                    reject = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rem_fmt <= LSC_FMT_AUTO;
            rem_src <= LSC_SRC_COAX;
            rem_txen <= 1'b0;
            ovr <= 3'h0;
            aspect <= `LSC_ASPECT_RST;
            bars <= `LSC_BARS_RST;
        end else begin
            rem_fmt <= next_rem_fmt;
            rem_src <= next_rem_src;
            rem_txen <= next_rem_txen;
            ovr <= next_ovr;
            aspect <= next_aspect;
            bars <= next_bars;
        end
    end

    // output selection, registered so every output comes from a flop
    lsc_fmt_t next_cfg_fmt;
    lsc_src_t next_cfg_src;
    logic next_txen_eff;
    logic [1:0] next_fiber_tx_en;

    always_comb begin
        next_cfg_fmt = local_fmt;
        next_cfg_src = local_src;
        next_txen_eff = local_txen;
        if (remote_mode && ovr[0]) begin
            next_cfg_fmt = rem_fmt;
        end
        if (remote_mode && ovr[1]) begin
            next_cfg_src = rem_src;
        end
        if (remote_mode && ovr[2]) begin
            next_txen_eff = rem_txen;
        end
        // an unfitted transmitter is never driven, whatever the setting says
        next_fiber_tx_en = next_txen_eff ? tx_fitted : 2'h0;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_fmt <= LSC_FMT_AUTO;
            cfg_src <= LSC_SRC_COAX;
            fiber_tx_en <= 2'h0;
            cfg_aspect <= `LSC_ASPECT_RST;
            cfg_bars <= `LSC_BARS_RST;
            remote_active <= 1'b0;
            override_flags <= 3'h0;
            remote_ack <= 1'b0;
            remote_rej <= 1'b0;
        end else begin
            cfg_fmt <= next_cfg_fmt;
            cfg_src <= next_cfg_src;
            fiber_tx_en <= next_fiber_tx_en;
            cfg_aspect <= aspect;
            cfg_bars <= bars;
            remote_active <= remote_mode;
            override_flags <= ovr;
            remote_ack <= accept;
            remote_rej <= reject;
        end
    end

    sequence s_release_wr;
        remote_wr && remote_mode && remote_sel == `LSC_PID_RELEASE;
    endsequence

    sequence s_quiet;
        !remote_wr [*2];
    endsequence

    AST_LOCAL_LOCKOUT: assert property (@(posedge mclk) disable iff (!arst_n)
        remote_wr && !remote_mode |=> !remote_ack && !remote_rej && $stable(ovr) && $stable(aspect))
        else $error("remote write taken in local mode");
    AST_REMOTE_TAKEN: assert property (@(posedge mclk) disable iff (!arst_n)
        remote_wr && remote_mode && remote_sel == `LSC_PID_BARS |=> remote_ack && bars == $past(remote_data[0]))
        else $error("remote write not taken in remote mode");
    AST_FMT_PRIORITY: assert property (@(posedge mclk) disable iff (!arst_n)
        remote_mode && ovr[0] |=> cfg_fmt == $past(rem_fmt))
        else $error("remote format lost priority");
    AST_LOCAL_FMT: assert property (@(posedge mclk) disable iff (!arst_n)
        !remote_mode |=> cfg_fmt == $past(local_fmt) && cfg_src == $past(local_src))
        else $error("local mode output not from switches");
    AST_TX_FITTED: assert property (@(posedge mclk) disable iff (!arst_n)
        fiber_tx_en != 2'h0 |-> ($past(tx_fitted) & fiber_tx_en) == fiber_tx_en)
        else $error("unfitted transmitter driven");
    AST_TX_SWITCH_OFF: assert property (@(posedge mclk) disable iff (!arst_n)
        !remote_mode && !local_txen |=> fiber_tx_en == 2'h0)
        else $error("fiber outputs on with switch off");
    AST_REMOTE_ONLY: assert property (@(posedge mclk) disable iff (!arst_n)
        $changed(cfg_aspect) |-> $past(remote_ack) && $past(remote_sel, 2) == `LSC_PID_ASPECT)
        else $error("remote-only parameter changed without write");
    AST_RELEASE: assert property (@(posedge mclk) disable iff (!arst_n)
        s_release_wr ##1 s_quiet |-> override_flags == 3'h0)
        else $error("release left an override active");
    AST_SRC_REMOTE: assert property (@(posedge mclk) disable iff (!arst_n)
        remote_wr && remote_mode && remote_sel == `LSC_PID_SRC && remote_data == 4'h3 |=> remote_rej ##1 !remote_ack)
        else $error("illegal source code not refused");
endmodule // lsc_config
`default_nettype wire

// [test/lsc_remote_card.sv]
// Purpose: model of the switch banks and of the remote network card
// Assumes: drives only just after a rising edge of mclk
// Notes: idle selector and data carry the inverse of the last write, so nothing can lean on a held value
`timescale 1ns/1ns
`default_nettype none
`include "lsc_params.svh"
module lsc_remote_card (
    // clock
    input wire logic mclk,
    // answer from the decoder
    input wire logic remote_ack,
    input wire logic remote_rej,
    // switch banks and fitted transmitters
    output logic [`LSC_BANK_W-1:0] switch_bank_a,
    output logic [`LSC_BANK_W-1:0] switch_bank_b,
    output logic [1:0] tx_fitted,
    // remote path
    output logic remote_wr,
    output logic [`LSC_SEL_W-1:0] remote_sel,
    output logic [`LSC_DATA_W-1:0] remote_data
);
    initial begin
        switch_bank_a = 8'h00;
        switch_bank_b = 8'h00;
        tx_fitted = 2'h0;
        remote_wr = 1'b0;
        remote_sel = 3'h7;
        remote_data = 4'hf;
    end
    // sampled at the next edge, visible one edge later
    task automatic set_sw(input logic [7:0] a, input logic [7:0] b, input logic [1:0] fit);
        @(posedge mclk);
        switch_bank_a <= a;
        switch_bank_b <= b;
        tx_fitted <= fit;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic write(input logic [2:0] sel, input logic [3:0] data, output logic ack, output logic rej);
        @(posedge mclk);
        remote_wr <= 1'b1;
        remote_sel <= sel;
        remote_data <= data;
        @(posedge mclk);
        remote_wr <= 1'b0;
        remote_sel <= ~sel;
        remote_data <= ~data;
        #1;
        ack = remote_ack;
        rej = remote_rej;
    endtask
endmodule // lsc_remote_card
`default_nettype wire

// [test/lsc_config_bench.sv]
// Purpose: self-checking bench of the switch configuration decoder
// Assumes: partner model drives the switch, fitted and remote inputs; the bench drives clock and reset
// Notes: waits are fixed by the design latencies; a watchdog bounds the run
`timescale 1ns/1ns
`default_nettype none
`include "lsc_params.svh"
module lsc_config_bench;
    import lsc_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    wire logic [7:0] sw_a, sw_b;
    wire logic [1:0] fit, tx_en, aspect;
    wire logic wr, ack_o, rej_o, bars, active;
    wire logic [2:0] sel, flags;
    wire logic [3:0] data;
    lsc_fmt_t fmt;
    lsc_src_t src;
    integer n_mismatch = 0;
    integer n_compared = 0;
    always #5 mclk = ~mclk;
    lsc_config lsc_config_i (.mclk(mclk), .arst_n(arst_n), .switch_bank_a(sw_a), .switch_bank_b(sw_b),
        .tx_fitted(fit), .remote_wr(wr), .remote_sel(sel), .remote_data(data), .remote_ack(ack_o),
        .remote_rej(rej_o), .cfg_fmt(fmt), .cfg_src(src), .fiber_tx_en(tx_en), .cfg_aspect(aspect),
        .cfg_bars(bars), .remote_active(active), .override_flags(flags));
    lsc_remote_card lsc_remote_card_i (.mclk(mclk), .remote_ack(ack_o), .remote_rej(rej_o),
        .switch_bank_a(sw_a), .switch_bank_b(sw_b), .tx_fitted(fit), .remote_wr(wr),
        .remote_sel(sel), .remote_data(data));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr_chk(input logic [2:0] s, input logic [3:0] d, input logic eack, input logic erej);
        logic a, r;
        lsc_remote_card_i.write(s, d, a, r);
        chk("ack", {7'h0, a}, {7'h0, eack});
        chk("rej", {7'h0, r}, {7'h0, erej});
        // settings and override flags settle one edge after the answer
        @(posedge mclk);
        #1;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        #1;
        chk("fmt_rst", fmt, 8'h0);
        chk("aspect_rst", aspect, 8'h0);
        chk("bars_rst", bars, 8'h0);
        chk("fiber_rst", tx_en, 8'h0);
        // every format code and every source code, illegal ones included
        for (int c = 0; c < 16; c++) begin
            lsc_remote_card_i.set_sw(8'h00, {1'b0, c[0], c[1], c[0], c[1], c[2], c[3], 1'b0}, 2'b11);
            chk("fmt", fmt, (c <= 6) ? 8'(c) : 8'h0);
            chk("src", src, (c % 4 <= 2) ? 8'(c % 4) : 8'h0);
        end
        for (int i = 0; i < 8; i++) begin
            lsc_remote_card_i.set_sw({4'h0, i[2], 3'h0}, 8'h00, i[1:0]);
            chk("fiber", tx_en, {6'h0, {2{i[2]}} & i[1:0]});
        end
        lsc_remote_card_i.set_sw(8'h08, 8'h50, 2'b11);
        wr_chk(3'h0, 4'h3, 1'b0, 1'b0);
        chk("fmt_local", fmt, 8'h1);
        chk("active_off", active, 8'h0);
        lsc_remote_card_i.set_sw(8'h09, 8'h50, 2'b11);
        chk("active_on", active, 8'h1);
        wr_chk(3'h0, 4'h3, 1'b1, 1'b0);
        chk("fmt_ovr", fmt, 8'h3);
        chk("flags", flags, 8'h1);
        wr_chk(3'h1, 4'h2, 1'b1, 1'b0);
        chk("src_ovr", src, 8'h2);
        wr_chk(3'h2, 4'h0, 1'b1, 1'b0);
        @(posedge mclk);
        #1;
        chk("fiber_ovr", tx_en, 8'h0);
        chk("flags_all", flags, 8'h7);
        wr_chk(3'h3, 4'h2, 1'b1, 1'b0);
        chk("aspect", aspect, 8'h2);
        wr_chk(3'h4, 4'h1, 1'b1, 1'b0);
        chk("bars", bars, 8'h1);
        wr_chk(3'h6, 4'h0, 1'b0, 1'b1);
        wr_chk(3'h0, 4'h7, 1'b0, 1'b1);
        wr_chk(3'h1, 4'h3, 1'b0, 1'b1);
        chk("fmt_kept", fmt, 8'h3);
        chk("src_kept", src, 8'h2);
        lsc_remote_card_i.set_sw(8'h08, 8'h50, 2'b11);
        @(posedge mclk);
        #1;
        chk("fmt_lock", fmt, 8'h1);
        chk("fiber_lock", tx_en, 8'h3);
        lsc_remote_card_i.set_sw(8'h09, 8'h50, 2'b11);
        chk("fmt_back", fmt, 8'h3);
        wr_chk(3'h5, 4'h0, 1'b1, 1'b0);
        chk("flags_rel", flags, 8'h0);
        chk("fmt_rel", fmt, 8'h1);
        conclude();
    end
endmodule // lsc_config_bench
`default_nettype wire
